// ---- core/svo_pkg.sv ----
// Constants shared by the sensor video output timing generator.
package svo_pkg;

    // ------------------------------------------------------------------
    // Register port geometry and word offsets
    // ------------------------------------------------------------------
    localparam int          REG_AW      = 4;
    localparam int          REG_DW      = 16;
    localparam logic [3:0]  ADDR_CTRL   = 4'h0;
    localparam logic [3:0]  ADDR_ROW    = 4'h1;
    localparam logic [3:0]  ADDR_COL    = 4'h2;
    localparam logic [3:0]  ADDR_HBLANK = 4'h3;
    localparam logic [3:0]  ADDR_VBLANK = 4'h4;
    localparam logic [3:0]  ADDR_INTEG  = 4'h5;
    localparam logic [3:0]  ADDR_COMMIT = 4'h6;
    localparam logic [3:0]  ADDR_STATUS = 4'h7;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int          CTRL_EN_BIT   = 0;
    localparam int          STAT_BUSY_BIT = 0;
    localparam int          STAT_FV_BIT   = 1;
    localparam int          STAT_WIN_BIT  = 2;
    localparam logic [15:0] INTEG_MASK    = 16'h0fff;

    // ------------------------------------------------------------------
    // Values after reset and lowest legal settings
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_CTRL   = 16'h0000;
    localparam logic [15:0] RST_ROW    = 16'h01e7;
    localparam logic [15:0] RST_COL    = 16'h0287;
    localparam logic [15:0] RST_HBLANK = 16'h0026;
    localparam logic [15:0] RST_VBLANK = 16'h0004;
    localparam logic [15:0] RST_INTEG  = 16'h0000;
    localparam logic [15:0] MIN_ROW    = 16'h0008;
    localparam logic [15:0] MIN_COL    = 16'h0008;
    localparam logic [15:0] MIN_HBLANK = 16'h0009;

    // ------------------------------------------------------------------
    // Counter widths in bits, and timing offsets in columns, master clocks or rows
    // ------------------------------------------------------------------
    localparam int HW            = 18;
    localparam int VW            = 17;
    localparam int COL_OFS       = 7;
    localparam int ROWT_OFS      = 114;
    localparam int P1_OFS        = 112;
    localparam int P2_LEN        = 14;
    localparam int FV_LEAD       = 6;
    localparam int ACT_ROW_OFS   = 7;
    localparam int FRAME_ROW_OFS = 2;
    localparam int CODE_LEN      = 4;

    // ------------------------------------------------------------------
    // Embedded synchronisation code bytes
    // ------------------------------------------------------------------
    localparam logic [7:0] SYNC_B0     = 8'hff;
    localparam logic [7:0] SYNC_B1     = 8'h00;
    localparam logic [7:0] CODE_FRAME  = 8'ha0;
    localparam logic [7:0] CODE_LSTART = 8'h80;
    localparam logic [7:0] CODE_LEND   = 8'hb0;
    localparam logic [7:0] BLANK_BYTE  = 8'h00;

endpackage

// ---- core/svo_timing_gen.sv ----
// Video output timing generator: register port, settings crossing and pixel stream.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Summary of operation
// - Pixel data change on a falling master clock edge and the pixel strobe rises on the next rising edge.
// - Line and frame qualifiers change on the same falling edge as the pixel data.
// - The line qualifier rises with a row's first valid pixel and falls as its last pixel ends.
// - The frame qualifier rises six pixel clocks before the frame's first line qualifier rise.
// - The frame qualifier falls six pixel clocks after the frame's last line qualifier fall.
// - Frame start, line start and line end code words are embedded in the data stream.
// - Active row time is twice (columns - 7) and horizontal blanking twice (hblank + 121), hblank at least 9.
// - Row time is twice (columns + hblank + 114) master clocks.
// - Vertical blanking is (vblank + 9) rows plus horizontal blanking less both frame blankings.
// - The frame window lasts (rows - 7) row times less horizontal blanking plus both frame blankings.
// - Frame time is (rows + vblank + 2) row times.
// - A long integration row count stretches the frame to (integration rows + 1) row times.
// - One pixel strobe is issued per master clock.
// ----------------------------------------------------------------------

module svo_timing_gen
    import svo_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic [REG_AW-1:0] reg_addr,
    input  wire logic [REG_DW-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [REG_DW-1:0] reg_rdata,
    input  wire logic              master_clk,
    output logic      [7:0]        pixel_data_out,
    output logic                   pixel_strobe_out,
    output logic                   line_valid_out,
    output logic                   frame_valid_out
);

    // ------------------------------------------------------------------
    // Register file, system clock domain
    // ------------------------------------------------------------------
    logic [15:0] ctrl;
    logic [15:0] row_set;
    logic [15:0] col_set;
    logic [15:0] hb_set;
    logic [15:0] vb_set;
    logic [15:0] int_set;
    logic [15:0] x_row;
    logic [15:0] x_col;
    logic [15:0] x_hb;
    logic [15:0] x_vb;
    logic [15:0] x_int;
    logic        req_tog;
    logic        ack_m;
    logic        ack_s;
    logic        fv_m;
    logic        fv_s;
    logic        win_m;
    logic        win_s;
    logic        busy;

    function automatic logic [15:0] at_least(input logic [15:0] v, input logic [15:0] lo);
        at_least = (v < lo) ? lo : v;
    endfunction

    assign busy = req_tog ^ ack_s;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl    <= RST_CTRL;
            row_set <= RST_ROW;
            col_set <= RST_COL;
            hb_set  <= RST_HBLANK;
            vb_set  <= RST_VBLANK;
            int_set <= RST_INTEG;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_CTRL:   ctrl    <= reg_wdata & 16'h0001;
                ADDR_ROW:    row_set <= at_least(reg_wdata, MIN_ROW);
                ADDR_COL:    col_set <= at_least(reg_wdata, MIN_COL);
                ADDR_HBLANK: hb_set  <= at_least(reg_wdata, MIN_HBLANK);
                ADDR_VBLANK: vb_set  <= reg_wdata;
                ADDR_INTEG:  int_set <= reg_wdata & INTEG_MASK;
                default: begin
                end
            endcase
        end
    end

    // Settings travel as a stable word bundle plus a request toggle. A commit
    // while the previous one is still in flight is dropped, so the bundle
    // never changes while the link side may be copying it.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            x_row   <= RST_ROW;
            x_col   <= RST_COL;
            x_hb    <= RST_HBLANK;
            x_vb    <= RST_VBLANK;
            x_int   <= RST_INTEG;
            req_tog <= 1'b0;
        end else if (reg_wr && reg_addr == ADDR_COMMIT && !busy) begin
            x_row   <= row_set;
            x_col   <= col_set;
            x_hb    <= hb_set;
            x_vb    <= vb_set;
            x_int   <= int_set;
            req_tog <= ~req_tog;
        end
    end

    logic ack_src;
    logic fv_src;
    logic win_src;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ack_m <= 1'b0;
            ack_s <= 1'b0;
            fv_m  <= 1'b0;
            fv_s  <= 1'b0;
            win_m <= 1'b0;
            win_s <= 1'b0;
        end else begin
            ack_m <= ack_src;
            ack_s <= ack_m;
            fv_m  <= fv_src;
            fv_s  <= fv_m;
            win_m <= win_src;
            win_s <= win_m;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_CTRL:   reg_rdata <= ctrl;
                ADDR_ROW:    reg_rdata <= row_set;
                ADDR_COL:    reg_rdata <= col_set;
                ADDR_HBLANK: reg_rdata <= hb_set;
                ADDR_VBLANK: reg_rdata <= vb_set;
                ADDR_INTEG:  reg_rdata <= int_set;
                ADDR_STATUS: begin
                    reg_rdata                <= 16'h0000;
                    reg_rdata[STAT_BUSY_BIT] <= busy;
                    reg_rdata[STAT_FV_BIT]   <= fv_s;
                    reg_rdata[STAT_WIN_BIT]  <= win_s;
                end
                default:     reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // Link domain, rising master clock edges
    // ------------------------------------------------------------------
    logic        lrst_m;
    logic        lrst_n;
    logic        req_m;
    logic        req_s;
    logic        req_d;
    logic        en_m;
    logic        en_s;
    logic        new_tog;
    logic        r_tog;
    logic [15:0] p_row;
    logic [15:0] p_col;
    logic [15:0] p_hb;
    logic [15:0] p_vb;
    logic [15:0] p_int;

    assign ack_src = req_d;

    always_ff @(posedge master_clk) begin
        lrst_m <= reset_n;
        lrst_n <= lrst_m;
    end

    always_ff @(posedge master_clk) begin
        if (!lrst_n) begin
            req_m <= 1'b0;
            req_s <= 1'b0;
            req_d <= 1'b0;
            en_m  <= 1'b0;
            en_s  <= 1'b0;
        end else begin
            req_m <= req_tog;
            req_s <= req_m;
            req_d <= req_s;
            en_m  <= ctrl[CTRL_EN_BIT];
            en_s  <= en_m;
        end
    end

    always_ff @(posedge master_clk) begin
        if (!lrst_n) begin
            p_row   <= RST_ROW;
            p_col   <= RST_COL;
            p_hb    <= RST_HBLANK;
            p_vb    <= RST_VBLANK;
            p_int   <= RST_INTEG;
            new_tog <= 1'b0;
        end else if (req_s != req_d) begin
            p_row   <= x_row;
            p_col   <= x_col;
            p_hb    <= x_hb;
            p_vb    <= x_vb;
            p_int   <= x_int;
            new_tog <= ~new_tog;
        end
    end

    // The strobe is the difference of two flops: the falling edge copies the
    // rising-edge toggle, so the strobe is high only between a rise and a fall.
    logic f_tog;

    always_ff @(posedge master_clk) begin
        if (!lrst_n) begin
            r_tog <= 1'b0;
        end else begin
            r_tog <= ~r_tog;
        end
    end

    // ------------------------------------------------------------------
    // Link domain, falling master clock edges: geometry and outputs
    // ------------------------------------------------------------------
    logic          taken_tog;
    logic          running;
    logic [15:0]   a_row;
    logic [15:0]   a_col;
    logic [15:0]   a_hb;
    logic [15:0]   a_vb;
    logic [15:0]   a_int;
    logic [HW-1:0] hcnt;
    logic [VW-1:0] vcnt;
    logic          win_q;

    logic [HW-1:0] a_len;
    logic [HW-1:0] lv_start;
    logic [HW-1:0] lv_end;
    logic [HW-1:0] row_t;
    logic [VW-1:0] need_rows;
    logic [VW-1:0] rows_total;
    logic [VW-1:0] nact;

    always_comb begin
        a_len     = (HW'(a_col) - HW'(COL_OFS)) << 1;
        lv_start  = (HW'(a_hb) + HW'(P1_OFS)) << 1;
        lv_end    = lv_start + a_len;
        row_t     = (HW'(a_col) + HW'(a_hb) + HW'(ROWT_OFS)) << 1;
        need_rows = VW'(a_row) + VW'(a_vb) + VW'(FRAME_ROW_OFS);
        rows_total = (VW'(a_int) >= need_rows) ? VW'(a_int) + VW'(1) : need_rows;
        nact      = VW'(a_row) - VW'(ACT_ROW_OFS);
    end

    logic frame_end;

    assign frame_end = (hcnt == row_t - HW'(1)) && (vcnt == rows_total - VW'(1));

    // New settings and the enable are taken only between frames, so a frame
    // in progress always finishes with the geometry it started with.
    always_ff @(negedge master_clk) begin
        if (!lrst_n) begin
            running   <= 1'b0;
            hcnt      <= '0;
            vcnt      <= '0;
            taken_tog <= 1'b0;
            a_row     <= RST_ROW;
            a_col     <= RST_COL;
            a_hb      <= RST_HBLANK;
            a_vb      <= RST_VBLANK;
            a_int     <= RST_INTEG;
        end else if (!running || frame_end) begin
            running <= en_s;
            hcnt    <= '0;
            vcnt    <= '0;
            if (new_tog != taken_tog) begin
                taken_tog <= new_tog;
                a_row     <= p_row;
                a_col     <= p_col;
                a_hb      <= p_hb;
                a_vb      <= p_vb;
                a_int     <= p_int;
            end
        end else if (hcnt == row_t - HW'(1)) begin
            hcnt <= '0;
            vcnt <= vcnt + VW'(1);
        end else begin
            hcnt <= hcnt + HW'(1);
        end
    end

    logic       act_row;
    logic       first_row;
    logic       last_row;
    logic       pre_code;
    logic       post_code;
    logic [1:0] code_idx;
    logic [7:0] code_byte;
    logic [7:0] pix_byte;
    logic       next_lv;
    logic       next_fv;
    logic       next_win;
    logic [7:0] next_data;

    always_comb begin
        act_row   = running && (vcnt < nact);
        first_row = (vcnt == '0);
        last_row  = (vcnt == nact - VW'(1));
        pre_code  = (hcnt >= lv_start - HW'(CODE_LEN)) && (hcnt < lv_start);
        post_code = (hcnt >= lv_end) && (hcnt < lv_end + HW'(CODE_LEN));
        code_idx  = pre_code ? 2'(hcnt - (lv_start - HW'(CODE_LEN))) : 2'(hcnt - lv_end);
        case (code_idx)
            2'd0:    code_byte = SYNC_B0;
            2'd1:    code_byte = SYNC_B1;
            2'd2:    code_byte = SYNC_B1;
            default: code_byte = post_code ? CODE_LEND
                               : (first_row ? CODE_FRAME : CODE_LSTART);
        endcase
        // Test pattern kept clear of the code bytes, so a receiver can never
        // mistake image data for a synchronisation word.
        pix_byte  = {1'b0, 7'(hcnt - lv_start + HW'(vcnt))} | 8'h01;
        next_lv   = act_row && (hcnt >= lv_start) && (hcnt < lv_end);
        next_fv   = act_row && (!first_row || hcnt >= lv_start - HW'(FV_LEAD))
                            && (!last_row || hcnt < lv_end + HW'(FV_LEAD));
        next_win  = act_row && (!last_row || hcnt < lv_end + HW'(P2_LEN));
        if (next_lv) begin
            next_data = pix_byte;
        end else if (act_row && (pre_code || post_code)) begin
            next_data = code_byte;
        end else begin
            next_data = BLANK_BYTE;
        end
    end

    always_ff @(negedge master_clk) begin
        if (!lrst_n) begin
            pixel_data_out  <= BLANK_BYTE;
            line_valid_out  <= 1'b0;
            frame_valid_out <= 1'b0;
            win_q           <= 1'b0;
            f_tog           <= 1'b0;
        end else begin
            pixel_data_out  <= next_data;
            line_valid_out  <= next_lv;
            frame_valid_out <= next_fv;
            win_q           <= next_win;
            f_tog           <= r_tog;
        end
    end

    assign pixel_strobe_out = r_tog ^ f_tog;
    assign fv_src           = frame_valid_out;
    assign win_src          = win_q;

endmodule

`default_nettype wire

// ---- verification/svo_timing_gen_properties.sv ----
// Port-level checker for the video output timing generator.
`timescale 1ns/1ps
`default_nettype none

module svo_timing_properties
    import svo_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic [REG_AW-1:0] reg_addr,
    input  wire logic [REG_DW-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [REG_DW-1:0] reg_rdata,
    input  wire logic              master_clk,
    input  wire logic [7:0]        pixel_data_out,
    input  wire logic              pixel_strobe_out,
    input  wire logic              line_valid_out,
    input  wire logic              frame_valid_out
);
    logic [9:0] hi_val;

    // Data and qualifiers may only move at the master clock fall, so what is seen at the rise must stand.
    always_ff @(posedge master_clk) begin
        hi_val <= {pixel_data_out, line_valid_out, frame_valid_out};
    end

    sequence code_lead;
        pixel_data_out == SYNC_B0 ##1 (pixel_data_out == SYNC_B1) [*2]
        ##1 (pixel_data_out == CODE_LSTART || pixel_data_out == CODE_FRAME);
    endsequence

    sequence code_end;
        pixel_data_out == SYNC_B0 ##1 (pixel_data_out == SYNC_B1) [*2]
        ##1 pixel_data_out == CODE_LEND;
    endsequence

    data_stable_a: assert property (@(negedge master_clk) disable iff (!reset_n)
        pixel_data_out == hi_val[9:2]) else $error("pixel byte moved during high phase");
    qual_stable_a: assert property (@(negedge master_clk) disable iff (!reset_n)
        {line_valid_out, frame_valid_out} == hi_val[1:0]) else $error("qualifier moved early");
    strobe_low_a: assert property (@(posedge master_clk) disable iff (!reset_n)
        !pixel_strobe_out) else $error("strobe not low before master rise");
    strobe_high_a: assert property (@(negedge master_clk) disable iff (!reset_n)
        $past(pixel_strobe_out) |-> pixel_strobe_out) else $error("strobe missed a rise");
    line_start_a: assert property (@(posedge master_clk) disable iff (!reset_n)
        code_lead |=> $rose(line_valid_out)) else $error("line start code not followed by line");
    line_end_a: assert property (@(posedge master_clk) disable iff (!reset_n)
        $fell(line_valid_out) |-> code_end) else $error("line end code missing");
    fv_lead_a: assert property (@(posedge master_clk) disable iff (!reset_n)
        $rose(frame_valid_out) |-> (!line_valid_out) [*6] ##1 line_valid_out)
        else $error("frame lead wrong");
    fv_lag_a: assert property (@(posedge master_clk) disable iff (!reset_n)
        $fell(frame_valid_out) |-> $past(line_valid_out, 7) && !$past(line_valid_out, 6))
        else $error("frame lag wrong");
    pixel_byte_a: assert property (@(posedge master_clk) disable iff (!reset_n)
        line_valid_out |-> pixel_data_out != SYNC_B0 && pixel_data_out != BLANK_BYTE)
        else $error("code byte inside line");
    rdata_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
        !$past(reg_rd) |-> reg_rdata == '0) else $error("read data outside answer cycle");
    commit_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        reg_rd && reg_addr == ADDR_COMMIT |=> reg_rdata == '0) else $error("commit read not 0");
endmodule

bind svo_timing_gen svo_timing_properties u_props (
    .clk              (clk),
    .reset_n          (reset_n),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .master_clk       (master_clk),
    .pixel_data_out   (pixel_data_out),
    .pixel_strobe_out (pixel_strobe_out),
    .line_valid_out   (line_valid_out),
    .frame_valid_out  (frame_valid_out)
);

`default_nettype wire

// ---- verification/svo_capture_model.sv ----
// Behavioural capture port that measures the video stream it samples.
`timescale 1ns/1ps
`default_nettype none

module svo_capture_model (
    input  wire logic        pixel_strobe_out,
    input  wire logic [7:0]  pixel_data_out,
    input  wire logic        line_valid_out,
    input  wire logic        frame_valid_out,
    output logic      [31:0] frames,
    output logic      [31:0] frame_len,
    output logic      [31:0] row_len,
    output logic      [31:0] px_len,
    output logic      [31:0] lines,
    output logic      [31:0] lead,
    output logic      [31:0] lag,
    output logic      [31:0] pre0,
    output logic      [31:0] pre,
    output logic      [31:0] post,
    output logic      [31:0] bad
);
    int          cnt_f  = 0;
    int          cnt_r  = 0;
    int          fall_n = 99;
    int          ln     = 0;
    int          px     = 0;
    logic        pfv    = 1'b0;
    logic        plv    = 1'b0;
    logic [31:0] sh     = '0;

    initial begin
        {frames, frame_len, row_len, px_len, lines, lead, lag, pre0, pre, post, bad} = '0;
    end

    // Everything is taken at the strobe rise only; bytes outside lines are kept for codes.
    always @(posedge pixel_strobe_out) begin
        cnt_f++;
        cnt_r++;
        fall_n++;
        if (frame_valid_out && !pfv) begin
            if (frames != 0) frame_len = cnt_f;
            frames++;
            cnt_f = 0;
            ln = 0;
        end
        if (line_valid_out && !plv) begin
            if (ln == 0) lead = cnt_f;
            else row_len = cnt_r;
            if (ln == 0) pre0 = sh;
            else pre = sh;
            cnt_r = 0;
            px = 0;
            ln++;
        end
        if (line_valid_out) px++;
        if (line_valid_out && (pixel_data_out == 8'hff || pixel_data_out == 8'h00)) bad++;
        if (!line_valid_out && plv) begin
            px_len = px;
            fall_n = 0;
        end
        if (fall_n == 3) post = {sh[23:0], pixel_data_out};
        if (!frame_valid_out && pfv) begin
            lag = fall_n;
            lines = ln;
        end
        sh = {sh[23:0], pixel_data_out};
        pfv = frame_valid_out;
        plv = line_valid_out;
    end
endmodule

`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the video output timing generator.
`timescale 1ns/1ps
`default_nettype none

module tb
    import svo_pkg::*;
;
    logic              clk;
    logic              reset_n;
    logic [REG_AW-1:0] reg_addr;
    logic [REG_DW-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [REG_DW-1:0] reg_rdata;
    logic              master_clk;
    logic [7:0]        pixel_data_out;
    logic              pixel_strobe_out;
    logic              line_valid_out;
    logic              frame_valid_out;
    logic [31:0]       frames, frame_len, row_len, px_len, lines, lead, lag, pre0, pre, post, bad;
    logic [15:0]       rst_val [6] = '{RST_CTRL, RST_ROW, RST_COL, RST_HBLANK, RST_VBLANK, RST_INTEG};
    int                mismatches;
    int                total_checks;
    int                col;

    svo_timing_gen uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .master_clk(master_clk),
        .pixel_data_out(pixel_data_out), .pixel_strobe_out(pixel_strobe_out),
        .line_valid_out(line_valid_out), .frame_valid_out(frame_valid_out));

    svo_capture_model u_cap (.pixel_strobe_out(pixel_strobe_out), .pixel_data_out(pixel_data_out),
        .line_valid_out(line_valid_out), .frame_valid_out(frame_valid_out), .frames(frames),
        .frame_len(frame_len), .row_len(row_len), .px_len(px_len), .lines(lines), .lead(lead),
        .lag(lag), .pre0(pre0), .pre(pre), .post(post), .bad(bad));

    initial clk = 1'b0;
    always #10 clk = ~clk;

    // The odd start offset keeps the two clocks from ever lining up.
    initial begin
        master_clk = 1'b0;
        #7;
        forever #24 master_clk = ~master_clk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e, input string nm);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(nm, {16'h0000, e}, {16'h0000, reg_rdata});
    endtask

    task automatic wait_frames(input int n);
        int          k;
        logic [31:0] goal;
        k = 0;
        goal = frames + n;
        while (frames < goal && k < 60000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 60000) begin
            mismatches++;
            $display("MISMATCH frames expected %0d seen %0d", goal, frames);
        end
    endtask

    // ----------------------------------------------------------------------
    // Reference model of one configuration
    // ----------------------------------------------------------------------
    task automatic run_cfg(input int row, input int c, input int hw, input int vb, input int ig);
        int h;
        int t;
        int nr;
        h = (hw < 9) ? 9 : hw;
        t = 2 * (c + h + 114);
        nr = (ig >= row + vb + 2) ? ig + 1 : row + vb + 2;
        wr(ADDR_ROW, row[15:0]);
        wr(ADDR_COL, c[15:0]);
        wr(ADDR_HBLANK, hw[15:0]);
        wr(ADDR_VBLANK, vb[15:0]);
        wr(ADDR_INTEG, ig[15:0]);
        rd(ADDR_HBLANK, h[15:0], "hblank");
        wr(ADDR_COMMIT, 16'h0001);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= ADDR_STATUS;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("busy", 1, reg_rdata[STAT_BUSY_BIT]);
        // The enable must not reach an idle generator before the committed
        // settings do, or its first frame would run on the old geometry.
        repeat (20) @(posedge clk);
        wr(ADDR_CTRL, 16'h0001);
        wait_frames(3);
        chk("frame_len", nr * t, frame_len);
        chk("row_len", t, row_len);
        chk("px_len", 2 * (c - 7), px_len);
        chk("lines", row - 7, lines);
        chk("lead", 6, lead);
        chk("lag", 6, lag);
        chk("frame code", 32'hff0000a0, pre0);
        chk("line code", 32'hff000080, pre);
        chk("end code", 32'hff0000b0, post);
        chk("bad pixels", 0, bad);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        reset_n = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        mismatches = 0;
        total_checks = 0;
        void'($urandom(58));
        col = 8 + ($urandom % 8);
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(i[3:0], rst_val[i], "reset value");
        end
        rd(ADDR_STATUS, 16'h0000, "status");
        wr(4'hc, 16'hbeef);
        rd(4'hc, 16'h0000, "unmapped");
        rd(ADDR_COMMIT, 16'h0000, "commit");
        run_cfg(10, col, 3, 1, 0);
        run_cfg(10, col, 10, 0, 20);
        end_sim;
    end

    initial begin
        #2_000_000;
        mismatches++;
        $display("MISMATCH watchdog expected finish seen timeout");
        end_sim;
    end
endmodule

`default_nettype wire
